// >>> src/adc_seq_ctrl.sv
// register file and sample/convert sequencer for the converter
`timescale 1ns/1ps

module adc_seq_ctrl
	import adc_seq_pkg::*;
#(
	parameter int  SECOND_INSTANCE = 0,
	parameter int  ADDR_WIDTH      = 16
) (
	// clock and reset
	input  wire logic                  mclk,
	input  wire logic                  sys_rst,
	// apb slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic                       pready,
	output logic                       pslverr,
	output logic [31:0]                prdata,
	// trigger pins and timers
	input  wire logic                  trigPin,
	input  wire logic                  timerMatchA,
	input  wire logic                  timerMatchB,
	input  wire logic                  rcClockTick,
	input  wire logic [31:0]           scanSelect,
	// analog front end
	output logic                       trackHold,
	output logic                       convStart,
	output logic                       useRcClock,
	output logic                       simultaneous,
	output logic [1:0]                 activeChannel,
	output ref_sel_t                   refSel,
	output chan_sel_t                  chan0Sel,
	output chan_sel_t                  chan1Sel,
	output chan_sel_t                  chan2Sel,
	output chan_sel_t                  chan3Sel,
	// dma side
	output logic                       dmaStep,
	output logic [ADDR_WIDTH-1:0]      dmaOffset
);

	if (ADDR_WIDTH < 12) begin : g_width_check // largest fill offset is 16 x 128
		$error("ADDR_WIDTH too small for the largest fill offset");
	end

	// ****************************************************************
	// helpers
	// ****************************************************************
	// positive and negative inputs for channel k (0..2) of the channel 1-3 group
	function automatic chan_sel_t ch123Pick(input logic [1:0] neg, input logic pos,
	                                        input logic [4:0] k);
		chan_sel_t c;
		c.posInput = (pos ? INPUT_AN3 : 5'h00) + k;
		c.negIsRef = ~neg[1];
		c.negInput = (neg[0] ? INPUT_AN9 : INPUT_AN6) + k;
		return c;
	endfunction

	// next scan input above the current one, wrapping
	function automatic logic [4:0] scanNext(input logic [31:0] set, input logic [4:0] cur);
		logic [4:0] r;
		logic       hit;
		logic [4:0] idx;
		r = cur;
		hit = 1'b0;
		for (int i = 1; i <= 32; i++) begin
			idx = 5'(cur + 5'(i));
			if (!hit && set[idx]) begin
				r = idx;
				hit = 1'b1;
			end
		end
		return r;
	endfunction

	// ****************************************************************
	// pin synchroniser (three stages, second and third must agree)
	// ****************************************************************
	logic [2:0] pinSync;
	logic [2:0] next_pinSync;
	logic       pinLevel;
	logic       next_pinLevel;
	logic       pinEdge;

	always_comb begin
		next_pinSync = {pinSync[1:0], trigPin};
		next_pinLevel = (pinSync[1] == pinSync[2]) ? pinSync[2] : pinLevel;
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pinSync <= 3'h0;
			pinLevel <= 1'b0;
		end else begin
			pinSync <= next_pinSync;
			pinLevel <= next_pinLevel;
		end
	end

	assign pinEdge = next_pinLevel & ~pinLevel;

	// ****************************************************************
	// registers and sequencer state
	// ****************************************************************
	logic [15:0] ctrlOne, ctrlTwo, clkTiming, dmaSizing, ch123Sel, ch0Sel;
	logic [15:0] next_ctrlOne, next_ctrlTwo, next_clkTiming;
	logic [15:0] next_dmaSizing, next_ch123Sel, next_ch0Sel;
	seq_state_t  state, next_state;
	logic [7:0]  divCount, next_divCount;
	logic [4:0]  periodCount, next_periodCount;
	logic [4:0]  convCount, next_convCount;
	logic [1:0]  chanIdx, next_chanIdx;
	logic        useB, next_useB;
	logic [4:0]  scanPos, next_scanPos;
	logic [3:0]  opCount, next_opCount;
	logic        bufHalf, next_bufHalf;
	logic [ADDR_WIDTH-1:0] addrOfs, next_addrOfs;
	logic        step, next_step;
	logic        convPulse, next_convPulse;
	logic [31:0] rdata, next_rdata;
	logic        rdy, next_rdy;
	logic        err, next_err;

	// field views
	logic       resMode, autoStart, sampleOn, simSel;
	logic [2:0] trigSrc;
	logic [1:0] chanCount;
	logic [1:0] lastChan;
	logic       tick;
	logic       trigger;
	logic       apbAccess;
	logic       apbWrite;
	logic [15:0] wr16;

	assign resMode   = ctrlOne[POS_RESMODE];
	assign autoStart = ctrlOne[POS_AUTOSTART];
	assign sampleOn  = ctrlOne[POS_SAMPLE];
	assign trigSrc   = ctrlOne[POS_TRIG +: 3];
	assign simSel    = ctrlOne[POS_SIMSAMPLE] & ~resMode;
	assign chanCount = resMode ? 2'b00 : ctrlTwo[POS_CHCOUNT +: 2];
	assign lastChan  = chanCount[1] ? 2'd3 : (chanCount[0] ? 2'd1 : 2'd0);
	// conversion clock tick, divider ignored on rc clock
	assign tick = clkTiming[POS_CLKSRC] ? rcClockTick
	            : (divCount >= clkTiming[POS_CLKDIV +: 8]);
	// trigger sources, reserved codes never fire
	always_comb begin
		unique case (trigSrc)
			TRIG_PIN:     trigger = pinEdge;
			TRIG_TIMER_A: trigger = timerMatchA;
			TRIG_TIMER_B: trigger = timerMatchB;
			// counter ends sampling after programmed periods
			TRIG_COUNTER: trigger = tick && (periodCount >= clkTiming[POS_SAMPTIME +: 5]);
			default:      trigger = 1'b0;
		endcase
	end

	assign apbAccess = psel & penable & ~rdy;
	assign apbWrite  = apbAccess & pwrite;
	assign wr16      = pwdata[15:0];

	// ****************************************************************
	// next-state logic
	// ****************************************************************
	always_comb begin
		next_ctrlOne = ctrlOne;
		next_ctrlTwo = ctrlTwo;
		next_clkTiming = clkTiming;
		next_dmaSizing = dmaSizing;
		next_ch123Sel = ch123Sel;
		next_ch0Sel = ch0Sel;
		next_state = state;
		next_divCount = tick ? 8'h00 : 8'(divCount + 8'h01);
		next_periodCount = periodCount;
		next_convCount = convCount;
		next_chanIdx = chanIdx;
		next_useB = useB;
		next_scanPos = scanPos;
		next_opCount = opCount;
		next_bufHalf = bufHalf;
		next_addrOfs = addrOfs;
		next_step = 1'b0;
		next_convPulse = 1'b0;
		next_rdy = apbAccess;
		next_err = 1'b0;
		next_rdata = 32'h0000_0000;

		// software writes; done may only be cleared
		if (apbWrite) begin
			unique case (paddr)
				OFS_CTRL_ONE: begin
					next_ctrlOne = (wr16 & MASK_CTRL_ONE & ~16'h0001)
					             | (ctrlOne & wr16 & 16'h0001);
					// simultaneous bit only exists in 10-bit mode
					if (wr16[POS_RESMODE]) next_ctrlOne[POS_SIMSAMPLE] = 1'b0;
				end
				OFS_CTRL_TWO:   next_ctrlTwo = (wr16 & MASK_CTRL_TWO) | (ctrlTwo & 16'h0080);
				OFS_CLK_TIMING: next_clkTiming = wr16 & MASK_CLK;
				OFS_DMA_SIZING: next_dmaSizing = wr16 & MASK_DMA;
				OFS_CH123_SEL:  next_ch123Sel = wr16 & MASK_CH123;
				OFS_CH0_SEL:    next_ch0Sel = wr16 & MASK_CH0;
				OFS_SEQ_STATUS: ;
				default:        next_err = 1'b1;
			endcase
		end else if (apbAccess) begin
			unique case (paddr)
				// read views with hidden fields zeroed
				OFS_CTRL_ONE:   next_rdata = {16'h0000, ctrlOne & (resMode ? MASK_12BIT_ONE : 16'hffff)};
				OFS_CTRL_TWO:   next_rdata = {16'h0000, ctrlTwo & (resMode ? MASK_12BIT_TWO : 16'hffff)};
				OFS_CLK_TIMING: next_rdata = {16'h0000, clkTiming};
				OFS_DMA_SIZING: next_rdata = {16'h0000, dmaSizing};
				OFS_CH123_SEL:  next_rdata = {16'h0000, resMode ? 16'h0000 : ch123Sel};
				OFS_CH0_SEL:    next_rdata = {16'h0000, ch0Sel};
				OFS_SEQ_STATUS: next_rdata = {16'h0000, 4'h0, state, scanPos, useB, chanIdx};
				default:        next_err = 1'b1;
			endcase
		end

		// sequencer
		unique case (state)
			ST_IDLE: begin
				// sampling starts when sample enable is set
				if (next_ctrlOne[POS_SAMPLE] || autoStart) begin
					next_ctrlOne[POS_SAMPLE] = 1'b1;
					next_periodCount = 5'h00;
					next_state = ST_SAMPLE;
				end
			end
			ST_SAMPLE: begin
				if (tick && periodCount != 5'h1f) next_periodCount = 5'(periodCount + 5'h01);
				// software clear ends sampling on trigger 000
				if (trigSrc == TRIG_SOFTWARE && !next_ctrlOne[POS_SAMPLE]) begin
					next_state = ST_CONVERT;
				end else if (trigSrc != TRIG_SOFTWARE && trigger) begin
					next_ctrlOne[POS_SAMPLE] = 1'b0;
					next_state = ST_CONVERT;
				end
				if (next_state == ST_CONVERT) begin
					next_ctrlOne[POS_DONE] = 1'b0;
					next_chanIdx = 2'd0;
					next_convCount = 5'h00;
					next_convPulse = 1'b1;
				end
			end
			ST_CONVERT: begin
				if (tick) next_convCount = 5'(convCount + 5'h01);
				if (tick && convCount == 5'(CONV_TICKS - 1)) begin
					// simultaneous converts held channels back to back
					if (chanIdx != lastChan) begin
						next_chanIdx = 2'(chanIdx + 2'd1);
						next_convCount = 5'h00;
						next_convPulse = 1'b1;
					end else begin
						next_state = ST_NEXT;
					end
				end
			end
			ST_NEXT: begin
				// completion sets done; set wins over software clear
				next_ctrlOne[POS_DONE] = 1'b1;
				next_useB = ctrlTwo[POS_ALT] ? ~useB : 1'b0;
				if (ctrlTwo[POS_SCAN] && !useB) next_scanPos = scanNext(scanSelect, scanPos);
				if (opCount == ctrlTwo[POS_OPS +: 4]) begin
					next_opCount = 4'h0;
					next_step = 1'b1;
					// split halves or restart at start
					if (ctrlTwo[POS_SPLIT]) begin
						next_bufHalf = ~bufHalf;
						next_addrOfs = bufHalf ? '0
						             : ADDR_WIDTH'({4'h0, ctrlTwo[POS_OPS +: 4]} + 8'h01)
						               << dmaSizing[2:0];
					end else begin
						next_bufHalf = 1'b0;
						next_addrOfs = '0;
					end
				end else begin
					next_opCount = 4'(opCount + 4'h1);
				end
				next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ctrlOne <= RST_REG;
			ctrlTwo <= RST_REG;
			clkTiming <= RST_REG;
			dmaSizing <= RST_REG;
			ch123Sel <= RST_REG;
			ch0Sel <= RST_REG;
			state <= ST_IDLE;
			divCount <= 8'h00;
			periodCount <= 5'h00;
			convCount <= 5'h00;
			chanIdx <= 2'd0;
			useB <= 1'b0;
			scanPos <= 5'h00;
			opCount <= 4'h0;
			bufHalf <= 1'b0;
			addrOfs <= '0;
			step <= 1'b0;
			convPulse <= 1'b0;
			rdata <= 32'h0000_0000;
			rdy <= 1'b0;
			err <= 1'b0;
		end else begin
			ctrlOne <= {next_ctrlOne[15:8], next_ctrlOne[7:0]};
			ctrlTwo <= {next_ctrlTwo[15:8], next_bufHalf & next_ctrlTwo[POS_SPLIT],
			            next_ctrlTwo[6:0]};
			clkTiming <= next_clkTiming;
			dmaSizing <= next_dmaSizing;
			ch123Sel <= next_ch123Sel;
			ch0Sel <= next_ch0Sel;
			state <= next_state;
			divCount <= next_divCount;
			periodCount <= next_periodCount;
			convCount <= next_convCount;
			chanIdx <= next_chanIdx;
			useB <= next_useB;
			scanPos <= next_scanPos;
			opCount <= next_opCount;
			bufHalf <= next_bufHalf;
			addrOfs <= next_addrOfs;
			step <= next_step;
			convPulse <= next_convPulse;
			rdata <= next_rdata;
			rdy <= next_rdy;
			err <= next_err;
		end
	end

	// ****************************************************************
	// analog selections, registered
	// ****************************************************************
	ref_sel_t  next_refSel;
	chan_sel_t next_c0, next_c1, next_c2, next_c3;
	logic [7:0] selByte;
	logic [7:0] ch123Byte;
	logic [4:0] pos0;

	always_comb begin
		selByte = useB ? ch0Sel[15:8] : ch0Sel[7:0];
		ch123Byte = useB ? ch123Sel[15:8] : ch123Sel[7:0];
		// scan or fixed channel 0 positive, second instance 0-15
		pos0 = (ctrlTwo[POS_SCAN] && !useB) ? scanPos : selByte[4:0];
		if (SECOND_INSTANCE != 0) pos0[4] = 1'b0;
		next_c0.posInput = pos0;
		next_c0.negIsRef = ~selByte[7];
		next_c0.negInput = INPUT_AN1;
		next_c1 = ch123Pick(ch123Byte[2:1], ch123Byte[0], 5'd0);
		next_c2 = ch123Pick(ch123Byte[2:1], ch123Byte[0], 5'd1);
		next_c3 = ch123Pick(ch123Byte[2:1], ch123Byte[0], 5'd2);
		// reference select, 1xx falls back to supply
		next_refSel.extPos = ~ctrlTwo[POS_REFSEL + 2] & ctrlTwo[POS_REFSEL];
		next_refSel.extNeg = ~ctrlTwo[POS_REFSEL + 2] & ctrlTwo[POS_REFSEL + 1];
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			refSel <= '0;
			chan0Sel <= '0;
			chan1Sel <= '0;
			chan2Sel <= '0;
			chan3Sel <= '0;
			trackHold <= 1'b0;
			useRcClock <= 1'b0;
			simultaneous <= 1'b0;
			activeChannel <= 2'd0;
		end else begin
			refSel <= next_refSel;
			chan0Sel <= next_c0;
			chan1Sel <= next_c1;
			chan2Sel <= next_c2;
			chan3Sel <= next_c3;
			// track while sample enable is one
			trackHold <= next_ctrlOne[POS_SAMPLE];
			useRcClock <= next_clkTiming[POS_CLKSRC];
			// simultaneous only when more than one channel
			simultaneous <= simSel && (chanCount != 2'b00);
			activeChannel <= next_chanIdx;
		end
	end

	// ports straight from flip-flops
	assign pready    = rdy;
	assign pslverr   = err;
	assign prdata    = rdata;
	assign convStart = convPulse;
	assign dmaStep   = step;
	assign dmaOffset = addrOfs;

endmodule // adc_seq_ctrl

// >>> src/adc_seq_pkg.sv
// shared constants and types for the converter sequencer control block
package adc_seq_pkg;

	// ****************************************************************
	// register byte offsets
	// ****************************************************************
	localparam logic [7:0] OFS_CTRL_ONE   = 8'h00;
	localparam logic [7:0] OFS_CTRL_TWO   = 8'h04;
	localparam logic [7:0] OFS_CLK_TIMING = 8'h08;
	localparam logic [7:0] OFS_DMA_SIZING = 8'h0c;
	localparam logic [7:0] OFS_CH123_SEL  = 8'h10;
	localparam logic [7:0] OFS_CH0_SEL    = 8'h14;
	localparam logic [7:0] OFS_SEQ_STATUS = 8'h18;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int POS_DONE       = 0;
	localparam int POS_SAMPLE     = 1;
	localparam int POS_AUTOSTART  = 2;
	localparam int POS_SIMSAMPLE  = 3;
	localparam int POS_TRIG       = 5;
	localparam int POS_RESMODE    = 10;
	localparam int POS_ALT        = 0;
	localparam int POS_SPLIT      = 1;
	localparam int POS_OPS        = 2;
	localparam int POS_BUFHALF    = 7;
	localparam int POS_CHCOUNT    = 8;
	localparam int POS_SCAN       = 10;
	localparam int POS_REFSEL     = 13;
	localparam int POS_CLKDIV     = 0;
	localparam int POS_SAMPTIME   = 8;
	localparam int POS_CLKSRC     = 15;

	// ****************************************************************
	// reset values and writable masks
	// ****************************************************************
	localparam logic [15:0] RST_REG        = 16'h0000;
	localparam logic [15:0] MASK_CTRL_ONE  = 16'hb7ef;
	localparam logic [15:0] MASK_CTRL_TWO  = 16'he73f;
	localparam logic [15:0] MASK_CLK       = 16'h9fff;
	localparam logic [15:0] MASK_DMA       = 16'h0007;
	localparam logic [15:0] MASK_CH123     = 16'h0707;
	localparam logic [15:0] MASK_CH0       = 16'h9f9f;
	localparam logic [15:0] MASK_12BIT_ONE = 16'hfff7;
	localparam logic [15:0] MASK_12BIT_TWO = 16'hfcff;

	// ****************************************************************
	// codes and timing
	// ****************************************************************
	localparam logic [2:0] TRIG_SOFTWARE = 3'h0;
	localparam logic [2:0] TRIG_PIN      = 3'h1;
	localparam logic [2:0] TRIG_TIMER_A  = 3'h2;
	localparam logic [2:0] TRIG_TIMER_B  = 3'h4;
	localparam logic [2:0] TRIG_COUNTER  = 3'h7;
	localparam logic [7:0] CLKDIV_LIMIT  = 8'h40;
	localparam logic [4:0] INPUT_AN1     = 5'h01;
	localparam logic [4:0] INPUT_AN3     = 5'h03;
	localparam logic [4:0] INPUT_AN6     = 5'h06;
	localparam logic [4:0] INPUT_AN9     = 5'h09;
	localparam int         CONV_TICKS    = 12;

	// reference choice driven to the analog side
	typedef struct packed {
		logic extPos;
		logic extNeg;
	} ref_sel_t;

	// one input pair per sample/hold channel
	typedef struct packed {
		logic [4:0] posInput;
		logic       negIsRef;
		logic [4:0] negInput;
	} chan_sel_t;

	typedef enum logic [3:0] {
		ST_IDLE    = 4'b0001,
		ST_SAMPLE  = 4'b0010,
		ST_CONVERT = 4'b0100,
		ST_NEXT    = 4'b1000
	} seq_state_t;

endpackage

// >>> bench/adc_front_model.sv
// behavioural analog front end: rc oscillator and conversion tally
`timescale 1ns/1ps
module adc_front_model (
	// clock and reset
	input  wire logic mclk,
	input  wire logic sys_rst,
	// converter control
	input  wire logic trackHold,
	input  wire logic convStart,
	// oscillator and tally
	output logic      rcClockTick,
	output int        convCount
);
	logic [1:0] phase = 2'h0;

	// free running rc oscillator, one tick in four cycles
	always @(posedge mclk) begin
		phase <= phase + 2'h1;
	end
	assign rcClockTick = (phase == 2'h3);

	always @(posedge mclk) begin
		if (sys_rst)
			convCount <= 0;
		else if (convStart && !trackHold)
			convCount <= convCount + 1;
	end
endmodule // adc_front_model

// >>> bench/adc_seq_ctrl_asserts.sv
// port checker for the converter sequencer control block
`timescale 1ns/1ps
module adc_seq_ctrl_asserts (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	// apb
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic        pready,
	input  wire logic        pslverr,
	input  wire logic [31:0] prdata,
	// converter side
	input  wire logic        trackHold,
	input  wire logic        convStart,
	input  wire logic        useRcClock,
	input  wire logic        dmaStep
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);

	// ****
	// bus answer
	// ****
	sequence s_access;
		psel && penable && !pready;
	endsequence
	property p_one_wait;
		s_access |=> pready;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("ready not after one wait");
	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
	property p_idle_data;
		!pready |-> prdata == 32'h0;
	endproperty
	a_idle_data: assert property (p_idle_data) else $error("read data outside answer");
	property p_err_ready;
		pslverr |-> pready;
	endproperty
	a_err_ready: assert property (p_err_ready) else $error("error without ready");

	// ****
	// sequencer
	// ****
	sequence s_end_sample;
		$fell(trackHold);
	endsequence
	property p_sample_end;
		s_end_sample |-> ##[0:3] convStart;
	endproperty
	a_sample_end: assert property (p_sample_end) else $error("no conversion after sample");
	property p_no_conv_track;
		convStart |-> !trackHold;
	endproperty
	a_no_conv_track: assert property (p_no_conv_track) else $error("convert while tracking");
	property p_conv_gap;
		convStart |=> !convStart [*8];
	endproperty
	a_conv_gap: assert property (p_conv_gap) else $error("conversion cut short");
	property p_dma_pulse;
		dmaStep |=> !dmaStep;
	endproperty
	a_dma_pulse: assert property (p_dma_pulse) else $error("step held");
	property p_clk_src;
		!$stable(useRcClock) |-> $past(psel && penable && pwrite) ||
			$past(psel && penable && pwrite, 2);
	endproperty
	a_clk_src: assert property (p_clk_src) else $error("clock source moved alone");
endmodule // adc_seq_ctrl_asserts

bind adc_seq_ctrl adc_seq_ctrl_asserts chk_i (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .prdata(prdata),
	.trackHold(trackHold), .convStart(convStart), .useRcClock(useRcClock), .dmaStep(dmaStep));

// >>> bench/adc_seq_ctrl_bench.sv
// self-checking bench for the converter sequencer control block
`timescale 1ns/1ps
module adc_seq_ctrl_bench;
	import adc_seq_pkg::*;
	logic        mclk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        trigPin = 1'b0;
	logic        timerMatchA = 1'b0;
	logic        timerMatchB = 1'b0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, err, rcClockTick;
	logic        trackHold, convStart, useRcClock, simultaneous, dmaStep;
	logic [1:0]  activeChannel;
	ref_sel_t    refSel;
	chan_sel_t   chan0Sel, chan1Sel, chan2Sel, chan3Sel;
	logic [15:0] dmaOffset;
	int          failures = 0;
	int          checks_done = 0;
	int          steps = 0;
	int          run = 0;
	int          lastRun = 0;
	int          convCount;

	always #2.5 mclk = ~mclk;

	// design and far side
	adc_seq_ctrl DUT (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .trigPin(trigPin), .timerMatchA(timerMatchA),
		.timerMatchB(timerMatchB), .rcClockTick(rcClockTick), .scanSelect(32'h0000_0030),
		.trackHold(trackHold), .convStart(convStart), .useRcClock(useRcClock),
		.simultaneous(simultaneous), .activeChannel(activeChannel), .refSel(refSel),
		.chan0Sel(chan0Sel), .chan1Sel(chan1Sel), .chan2Sel(chan2Sel), .chan3Sel(chan3Sel),
		.dmaStep(dmaStep), .dmaOffset(dmaOffset));
	adc_front_model front (.mclk(mclk), .sys_rst(sys_rst), .trackHold(trackHold),
		.convStart(convStart), .rcClockTick(rcClockTick), .convCount(convCount));

	// tally steps and length of each tracking run
	always @(posedge mclk) begin
		if (dmaStep === 1'b1) steps <= steps + 1;
		if (trackHold === 1'b1) run <= run + 1;
		else if (run > 0) begin
			lastRun <= run;
			run <= 0;
		end
	end

	// ****
	// helpers
	// ****
	task automatic print_verdict;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			failures++;
			print_verdict();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		apb(1'b1, a, {16'h0, d});
	endtask
	task automatic rchk(input logic [7:0] a, input logic [15:0] e);
		apb(1'b0, a, 32'h0);
		chk($sformatf("register %h", a), {16'h0, e}, rd);
	endtask
	task automatic wait_done;
		int n;
		n = 0;
		do begin
			apb(1'b0, OFS_CTRL_ONE, 32'h0);
			n++;
		end while (rd[POS_DONE] !== 1'b1 && n < 100);
		chk("done flag", 32'h1, 32'(rd[POS_DONE]));
		if (n >= 100) print_verdict();
	endtask
	task automatic wait_conv(input int want);
		int n;
		n = 0;
		while (convCount < want && n < 3000) begin
			@(posedge mclk);
			n++;
		end
		if (n >= 3000) begin
			failures++;
			print_verdict();
		end
	endtask

	// ****
	// scenarios
	// ****
	task automatic t_regs;
		logic [7:0] ofs [6] = '{OFS_CTRL_ONE, OFS_CTRL_TWO, OFS_CLK_TIMING, OFS_DMA_SIZING,
			OFS_CH123_SEL, OFS_CH0_SEL};
		for (int i = 0; i < 6; i++) rchk(ofs[i], RST_REG);
		wr(OFS_CLK_TIMING, 16'hffff);
		rchk(OFS_CLK_TIMING, MASK_CLK);
		chk("rc select", 32'h1, 32'(useRcClock));
		wr(OFS_DMA_SIZING, 16'hffff);
		rchk(OFS_DMA_SIZING, MASK_DMA);
		wr(OFS_CH0_SEL, 16'hffff);
		rchk(OFS_CH0_SEL, MASK_CH0);
		wr(OFS_CH123_SEL, 16'hffff);
		rchk(OFS_CH123_SEL, MASK_CH123);
		apb(1'b0, 8'h1c, 32'h0);
		chk("slave error", 32'h1, 32'(err));
		wr(OFS_CLK_TIMING, 16'h0000);
		cyc(2);
		chk("rc select", 32'h0, 32'(useRcClock));
	endtask
	task automatic t_twelve;
		wr(OFS_CTRL_ONE, 16'h0408);
		rchk(OFS_CTRL_ONE, 16'h0400);
		wr(OFS_CTRL_TWO, 16'h0300);
		rchk(OFS_CTRL_TWO, 16'h0000);
		rchk(OFS_CH123_SEL, 16'h0000);
		wr(OFS_CTRL_ONE, 16'h0000);
	endtask
	task automatic t_ref;
		logic [1:0] e;
		for (int v = 0; v < 8; v++) begin
			wr(OFS_CTRL_TWO, {v[2:0], 13'h0});
			cyc(3);
			e = v[2] ? 2'h0 : {v[0], v[1]};
			chk("reference", 32'(e), 32'(refSel));
		end
		wr(OFS_CTRL_TWO, 16'h0000);
	endtask
	task automatic t_sel;
		logic [4:0] pos;
		logic [4:0] neg;
		for (int i = 0; i < 4; i++) begin
			wr(OFS_CH123_SEL, {13'h0, i[1:0], i[0]});
			wr(OFS_CH0_SEL, {8'h0, i[0], 2'h0, 3'h4, i[1:0]});
			cyc(3);
			pos = i[0] ? INPUT_AN3 : 5'h0;
			neg = i[0] ? INPUT_AN9 : INPUT_AN6;
			chk("ch1 positive", 32'(pos), 32'(chan1Sel.posInput));
			chk("ch3 positive", 32'(pos + 5'h2), 32'(chan3Sel.posInput));
			chk("ch1 reference", 32'(!i[1]), 32'(chan1Sel.negIsRef));
			if (i[1]) chk("ch3 negative", 32'(neg + 5'h2), 32'(chan3Sel.negInput));
			chk("ch0 positive", 32'({3'h4, i[1:0]}), 32'(chan0Sel.posInput));
			chk("ch0 reference", 32'(!i[0]), 32'(chan0Sel.negIsRef));
			if (i[0]) chk("ch0 negative", 32'(INPUT_AN1), 32'(chan0Sel.negInput));
		end
	endtask
	task automatic t_sw;
		int base;
		for (int c = 0; c < 4; c++) begin
			wr(OFS_CTRL_TWO, {6'h0, c[1:0], 8'h0});
			base = convCount;
			wr(OFS_CTRL_ONE, 16'h000a);
			cyc(20);
			chk("tracking", 32'h1, 32'(trackHold));
			chk("simultaneous", 32'(c != 0), 32'(simultaneous));
			wr(OFS_CTRL_ONE, 16'h0000);
			wait_done();
			chk("conversions", (c == 0) ? 1 : (c == 1) ? 2 : 4, convCount - base);
			chk("last channel", (c == 0) ? 0 : (c == 1) ? 1 : 3, 32'(activeChannel));
			rchk(OFS_CTRL_ONE, 16'h0001);
			wr(OFS_CTRL_ONE, 16'h0000);
			rchk(OFS_CTRL_ONE, 16'h0000);
		end
	endtask
	task automatic t_trig;
		logic [2:0] codes [3] = '{TRIG_PIN, TRIG_TIMER_A, TRIG_TIMER_B};
		int base;
		wr(OFS_CTRL_TWO, 16'h0000);
		for (int i = 0; i < 3; i++) begin
			base = convCount;
			wr(OFS_CTRL_ONE, {8'h0, codes[i], 5'h02});
			cyc(10);
			chk("waiting for trigger", 32'h1, 32'(trackHold));
			trigPin <= (codes[i] == TRIG_PIN);
			timerMatchA <= (codes[i] == TRIG_TIMER_A);
			timerMatchB <= (codes[i] == TRIG_TIMER_B);
			@(posedge mclk);
			timerMatchA <= 1'b0;
			timerMatchB <= 1'b0;
			wait_done();
			chk("triggered conversion", 32'h1, convCount - base);
			trigPin <= 1'b0;
			wr(OFS_CTRL_ONE, 16'h0000);
		end
	endtask
	// two software sequences: Sample B after the first, scanned Sample A after the second
	task automatic t_alt;
		logic [4:0] want [2] = '{5'h07, 5'h04};
		wr(OFS_CH0_SEL, 16'h0702);
		wr(OFS_CTRL_TWO, 16'h0401);
		for (int i = 0; i < 2; i++) begin
			wr(OFS_CTRL_ONE, 16'h0002);
			wr(OFS_CTRL_ONE, 16'h0000);
			wait_done();
			chk("ch0 alternate or scan", 32'(want[i]), 32'(chan0Sel.posInput));
		end
	endtask
	task automatic t_auto;
		int base;
		int s0;
		wr(OFS_DMA_SIZING, 16'h0001);
		wr(OFS_CTRL_TWO, 16'h0006);
		wr(OFS_CLK_TIMING, 16'h0301);
		base = convCount;
		s0 = steps;
		wr(OFS_CTRL_ONE, 16'h00e6);
		wait_conv(base + 2);
		wr(OFS_CTRL_ONE, 16'h00e0);
		cyc(60);
		chk("auto restarts", 32'h2, convCount - base);
		chk("sample length", 32'h1, 32'(lastRun >= 6 && lastRun <= 8));
		chk("dma steps", 32'h1, steps - s0);
		rchk(OFS_CTRL_TWO, 16'h0086);
		chk("fill offset", 32'h4, 32'(dmaOffset));
	endtask

	// ****
	// main sequence
	// ****
	initial begin
		repeat (8) @(posedge mclk);
		sys_rst <= 1'b0;
		t_regs();
		t_twelve();
		t_ref();
		t_sel();
		t_sw();
		t_trig();
		t_alt();
		t_auto();
		print_verdict();
	end
endmodule // adc_seq_ctrl_bench
